// [logic/dpllc_map.vh]
`ifndef DPLLC_MAP_VH
`define DPLLC_MAP_VH

// control word reset and writable bits
`define DPLLC_CTL_RESET     32'h04800080
`define DPLLC_CTL_WMASK     32'hCFFFEEFF

// field positions
`define DPLLC_VCO_BIT       31
`define DPLLC_FASTIO_BIT    30
`define DPLLC_MODE_HI       27
`define DPLLC_MODE_LO       26
`define DPLLC_P2_HI         25
`define DPLLC_P2_LO         24
`define DPLLC_P1S0_HI       23
`define DPLLC_P1S0_LO       16
`define DPLLC_REF_HI        15
`define DPLLC_REF_LO        13
`define DPLLC_MULT_HI       11
`define DPLLC_MULT_LO       9
`define DPLLC_P1S1_HI       7
`define DPLLC_P1S1_LO       0

// mode and select codes
`define DPLLC_MODE_NONLVDS  2'h1
`define DPLLC_MODE_LVDS     2'h2
`define DPLLC_P2SEL_SLOW    2'h0
`define DPLLC_P2SEL_FAST    2'h1
`define DPLLC_REF_STD       3'h0
`define DPLLC_REF_SUPER     3'h1
`define DPLLC_REF_SPREAD    3'h3
`define DPLLC_MULT_MAX      3'h3

// second post divider values
`define DPLLC_P2_LVDS_SLOW  4'hE
`define DPLLC_P2_LVDS_FAST  4'h7
`define DPLLC_P2_DAC_SLOW   4'hA
`define DPLLC_P2_DAC_FAST   4'h5

// divider formula terms
`define DPLLC_FB_OFFSET     2
`define DPLLC_MAJOR_WEIGHT  5

`endif

// [logic/dpllc_ratio.v]
`timescale 1ns/100ps
`include "dpllc_map.vh"

module dpllc_ratio #(
    parameter FB_W = 6
) (
    // clock and reset
    input  wire            clock,
    input  wire            rst,
    // divider settings in use
    input  wire [FB_W-1:0] major_feedback_div,
    input  wire [FB_W-1:0] minor_feedback_div,
    input  wire [FB_W-1:0] input_div,
    input  wire [7:0]      first_post_onehot,
    input  wire [3:0]      second_post_value,
    // ratio terms
    output reg  [9:0]      feedback_total,
    output reg  [6:0]      input_total,
    output reg  [6:0]      post_total
);

    // one-hot to divide value, zero when not one-hot
    function [3:0] p1_value;
        input [7:0] oh;
        integer k;
        begin
            p1_value = 4'h0;
            for (k = 0; k < 8; k = k + 1) begin
                if (oh == (8'h01 << k)) begin
                    p1_value = k[3:0] + 4'h1;
                end
            end
        end
    endfunction

    localparam [9:0] MAJ_WEIGHT = `DPLLC_MAJOR_WEIGHT;
    localparam [9:0] FB_OFS10   = `DPLLC_FB_OFFSET;
    localparam [6:0] FB_OFS7    = `DPLLC_FB_OFFSET;

    wire [9:0] major_ext;
    wire [9:0] minor_ext;
    wire [6:0] input_ext;
    wire [9:0] major_term;
    wire [9:0] minor_term;
    wire [3:0] p1_val;

    assign major_ext  = {{(10-FB_W){1'b0}}, major_feedback_div};
    assign minor_ext  = {{(10-FB_W){1'b0}}, minor_feedback_div};
    assign input_ext  = {{(7-FB_W){1'b0}}, input_div};
    assign major_term = MAJ_WEIGHT * (major_ext + FB_OFS10);
    assign minor_term = minor_ext + FB_OFS10;
    assign p1_val = p1_value(first_post_onehot);

    // dot = ref * feedback_total / (input_total * post_total)
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            feedback_total <= 10'h000;
            input_total    <= 7'h00;
            post_total     <= 7'h00;
        end else begin
            feedback_total <= major_term + minor_term; // [RL16]
            input_total    <= input_ext + FB_OFS7;
            post_total     <= {3'h0, p1_val} * {3'h0, second_post_value};
        end
    end

endmodule // dpllc_ratio

// [logic/dpllc_control.v]
`timescale 1ns/100ps
`include "dpllc_map.vh"

// Function
// [RL1] VCO bit stops PLL and dot clock
// [RL2] software sets fast IO clock when needed
// [RL3] mode field: non-LVDS default, LVDS, reserved
// [RL4] second post divider select per mode
// [RL5] set 0 first post divider one-hot
// [RL6] set 1 first post divider one-hot
// [RL7] divider byte write commits when PLL off
// [RL8] idle divisor set writable while other runs
// [RL9] fields double buffered to vertical blank
// [RL10] first post divider bytes act immediately
// [RL11] reference select not double buffered
// [RL12] writes ignored while panel protects
// [RL13] multiplier is factor minus one, 0..3
// [RL14] software programs multiplier after PLL stable
// [RL15] software writes zero to reserved bits
// [RL16] dot clock from feedback, input, post dividers
// [RL17] software assumes 120 or 100 MHz reference
// [RL18] software keeps VCO and feedback ranges
// [RL19] software keeps post divide ranges
// [RL20] software scales PLL for video rates
// [RL21] software uses 1.5x for deep color
// [RL22] software keeps per-mode clock ranges
// [RL23] vertical blank pulse moves all double buffered fields together
module dpllc_control #(
    parameter FB_W = 6
) (
    // clock and reset
    input  wire            clock,
    input  wire            rst,
    // register port
    input  wire            reg_write,
    input  wire [3:0]      reg_byte_en,
    input  wire [31:0]     reg_wdata,
    output wire [31:0]     reg_rdata,
    // transcoder and sequencer
    input  wire            vblank_pulse,
    input  wire            panel_protect,
    input  wire            divisor_set_sel,
    // pending divisors of the set in use
    input  wire [FB_W-1:0] pend_major_div,
    input  wire [FB_W-1:0] pend_minor_div,
    input  wire [FB_W-1:0] pend_input_div,
    // active controls to the analog core
    output reg             vco_power_on,
    output wire            pll_power_down,
    output wire            dot_clock_run,
    output reg             fast_io_clock_on,
    output reg  [1:0]      pll_output_mode,
    output reg  [1:0]      second_post_divide_sel,
    output reg  [2:0]      video_clock_multiplier,
    output wire [2:0]      reference_select,
    output wire [7:0]      set0_first_post_divide,
    output wire [7:0]      set1_first_post_divide,
    // committed divisors
    output reg             divisor_commit,
    output reg  [FB_W-1:0] major_feedback_div,
    output reg  [FB_W-1:0] minor_feedback_div,
    output reg  [FB_W-1:0] input_div,
    // ratio terms and status
    output wire [9:0]      feedback_total,
    output wire [6:0]      input_total,
    output wire [6:0]      post_total,
    output reg             config_error
);

    // one-hot test, used for both divisor sets
    function onehot8;
        input [7:0] v;
        begin
            onehot8 = (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
        end
    endfunction

    // second post divider value from mode and select
    function [3:0] p2_value;
        input [1:0] mode;
        input [1:0] sel;
        begin
            if (mode == `DPLLC_MODE_LVDS) begin
                p2_value = (sel == `DPLLC_P2SEL_FAST) ? `DPLLC_P2_LVDS_FAST
                                                      : `DPLLC_P2_LVDS_SLOW;
            end else begin
                p2_value = (sel == `DPLLC_P2SEL_FAST) ? `DPLLC_P2_DAC_FAST
                                                      : `DPLLC_P2_DAC_SLOW;
            end
        end
    endfunction

    reg  [31:0] ctl_reg;
    reg  [31:0] ctl_next;
    wire        wr_ok;
    wire [31:0] lane_mask;
    wire [31:0] wr_mask;
    wire [31:0] mult_mask;
    wire        mult_legal;
    wire        p1_hit;
    wire [7:0]  p1_in_use;
    wire [3:0]  p2_in_use;
    wire [1:0]  mode_field;
    wire [1:0]  p2_field;
    wire [2:0]  ref_field;
    wire        mode_bad;
    wire        p2_bad;
    wire        ref_bad;
    wire        p1_bad;

    // write gating and byte lanes
    assign wr_ok = reg_write & ~panel_protect; // [RL12]
    assign lane_mask = {{8{reg_byte_en[3]}}, {8{reg_byte_en[2]}},
                        {8{reg_byte_en[1]}}, {8{reg_byte_en[0]}}};
    assign mult_legal = reg_wdata[`DPLLC_MULT_HI:`DPLLC_MULT_LO] <= `DPLLC_MULT_MAX; // [RL13]
    assign mult_mask = mult_legal ? 32'hFFFFFFFF : ~(32'h00000007 << `DPLLC_MULT_LO);
    // reserved bits never stored and read as zero
    assign wr_mask = lane_mask & `DPLLC_CTL_WMASK & mult_mask;

    // first stage, written and read back
    always @* begin
        ctl_next = ctl_reg;
        if (wr_ok) begin
            ctl_next = (ctl_reg & ~wr_mask) | (reg_wdata & wr_mask);
        end
    end

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ctl_reg <= `DPLLC_CTL_RESET;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    assign reg_rdata = ctl_reg;

    // second stage, loaded at vertical blank
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            vco_power_on           <= 1'b0;
            fast_io_clock_on       <= 1'b0;
            pll_output_mode        <= `DPLLC_MODE_NONLVDS;
            second_post_divide_sel <= `DPLLC_P2SEL_SLOW;
            video_clock_multiplier <= 3'h0;
        end else if (vblank_pulse) begin // [RL9] [RL23]
            vco_power_on           <= ctl_reg[`DPLLC_VCO_BIT]; // [RL1]
            fast_io_clock_on       <= ctl_reg[`DPLLC_FASTIO_BIT];
            pll_output_mode        <= ctl_reg[`DPLLC_MODE_HI:`DPLLC_MODE_LO]; // [RL3]
            second_post_divide_sel <= ctl_reg[`DPLLC_P2_HI:`DPLLC_P2_LO]; // [RL4]
            video_clock_multiplier <= ctl_reg[`DPLLC_MULT_HI:`DPLLC_MULT_LO]; // [RL13]
        end
    end

    // vco off means lowest power and no dot clock
    assign pll_power_down = ~vco_power_on; // [RL1]
    assign dot_clock_run  = vco_power_on; // [RL1]

    // fields that bypass the second stage
    assign reference_select       = ctl_reg[`DPLLC_REF_HI:`DPLLC_REF_LO]; // [RL11]
    assign set0_first_post_divide = ctl_reg[`DPLLC_P1S0_HI:`DPLLC_P1S0_LO]; // [RL5] [RL10]
    assign set1_first_post_divide = ctl_reg[`DPLLC_P1S1_HI:`DPLLC_P1S1_LO]; // [RL6] [RL10]

    // divider byte write while PLL off commits pending divisors
    assign p1_hit = wr_ok & (reg_byte_en[2] | reg_byte_en[0]);

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            divisor_commit     <= 1'b0;
            major_feedback_div <= {FB_W{1'b0}};
            minor_feedback_div <= {FB_W{1'b0}};
            input_div          <= {FB_W{1'b0}};
        end else begin
            divisor_commit <= p1_hit & ~vco_power_on; // [RL7]
            if ((p1_hit & ~vco_power_on) | (vblank_pulse & vco_power_on)) begin // [RL7] [RL9]
                major_feedback_div <= pend_major_div;
                minor_feedback_div <= pend_minor_div;
                input_div          <= pend_input_div;
            end
        end
    end

    // divisor set in use drives the PLL; the other stays writable
    assign p1_in_use = divisor_set_sel ? set1_first_post_divide
                                       : set0_first_post_divide; // [RL8]
    assign p2_in_use = p2_value(pll_output_mode, second_post_divide_sel); // [RL4]

    dpllc_ratio #(
        .FB_W(FB_W)
    ) u_ratio (
        .clock              (clock),
        .rst                (rst),
        .major_feedback_div (major_feedback_div),
        .minor_feedback_div (minor_feedback_div),
        .input_div          (input_div),
        .first_post_onehot  (p1_in_use),
        .second_post_value  (p2_in_use),
        .feedback_total     (feedback_total),
        .input_total        (input_total),
        .post_total         (post_total)
    );

    // reserved codes reported as a status level
    assign mode_field = ctl_reg[`DPLLC_MODE_HI:`DPLLC_MODE_LO];
    assign p2_field   = ctl_reg[`DPLLC_P2_HI:`DPLLC_P2_LO];
    assign ref_field  = ctl_reg[`DPLLC_REF_HI:`DPLLC_REF_LO];
    assign mode_bad = (mode_field != `DPLLC_MODE_NONLVDS) &&
                      (mode_field != `DPLLC_MODE_LVDS); // [RL3]
    assign p2_bad   = (p2_field != `DPLLC_P2SEL_SLOW) &&
                      (p2_field != `DPLLC_P2SEL_FAST); // [RL4]
    assign ref_bad  = (ref_field != `DPLLC_REF_STD) &&
                      (ref_field != `DPLLC_REF_SUPER) &&
                      (ref_field != `DPLLC_REF_SPREAD); // [RL11]
    assign p1_bad   = ~onehot8(set0_first_post_divide) |
                      ~onehot8(set1_first_post_divide); // [RL5] [RL6]

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            config_error <= 1'b0;
        end else begin
            config_error <= mode_bad | p2_bad | ref_bad | p1_bad;
        end
    end

endmodule // dpllc_control

// [test/dpllc_properties.sv]
`timescale 1ns/100ps
module dpllc_properties (
    // clock and reset
    input logic        clock,
    input logic        rst,
    // register port
    input logic        reg_write,
    input logic [3:0]  reg_byte_en,
    input logic [31:0] reg_rdata,
    input logic        vblank_pulse,
    input logic        panel_protect,
    // active controls
    input logic        vco_power_on,
    input logic        pll_power_down,
    input logic        dot_clock_run,
    input logic        fast_io_clock_on,
    input logic [1:0]  pll_output_mode,
    input logic [1:0]  second_post_divide_sel,
    input logic [2:0]  video_clock_multiplier,
    input logic [2:0]  reference_select,
    input logic [7:0]  set0_first_post_divide,
    input logic [7:0]  set1_first_post_divide,
    input logic        divisor_commit
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    vco_stops_pll_a: assert property (pll_power_down == !vco_power_on && dot_clock_run == vco_power_on)
        else $error("power down does not follow vco enable");
    mode_moves_a: assert property (vblank_pulse |=> pll_output_mode == $past(reg_rdata[27:26]))
        else $error("mode not moved at vertical blank");
    divide_sel_moves_a: assert property (vblank_pulse |=> second_post_divide_sel == $past(reg_rdata[25:24]))
        else $error("second divider select not moved");
    vco_moves_a: assert property (vblank_pulse |=> vco_power_on == $past(reg_rdata[31]) && fast_io_clock_on == $past(reg_rdata[30]))
        else $error("enables not moved at vertical blank");
    fields_hold_a: assert property (!vblank_pulse |=> $stable({vco_power_on, pll_output_mode, video_clock_multiplier}))
        else $error("active field changed without vertical blank");
    divider_immediate_a: assert property (set0_first_post_divide == reg_rdata[23:16] && set1_first_post_divide == reg_rdata[7:0])
        else $error("first post divider not immediate");
    reference_immediate_a: assert property (reference_select == reg_rdata[15:13])
        else $error("reference select not immediate");
    protect_blocks_a: assert property (reg_write && panel_protect |=> $stable(reg_rdata))
        else $error("write taken while protected");
    commit_pulse_a: assert property (reg_write && !panel_protect && (reg_byte_en[2] || reg_byte_en[0]) && !vco_power_on |=> divisor_commit)
        else $error("divisor commit missing");
    commit_cause_a: assert property (divisor_commit |-> $past(reg_write && !panel_protect && (reg_byte_en[2] || reg_byte_en[0]) && !vco_power_on))
        else $error("divisor commit without divider write");
    multiplier_range_a: assert property (video_clock_multiplier <= 3'h3)
        else $error("multiplier out of range");

    cover property (vblank_pulse ##1 vco_power_on);
    cover property (divisor_commit);
    cover property (reg_write && panel_protect);
endmodule // dpllc_properties

bind dpllc_control dpllc_properties u_props (.clock, .rst, .reg_write, .reg_byte_en, .reg_rdata,
    .vblank_pulse, .panel_protect, .vco_power_on, .pll_power_down, .dot_clock_run,
    .fast_io_clock_on, .pll_output_mode, .second_post_divide_sel, .video_clock_multiplier,
    .reference_select, .set0_first_post_divide, .set1_first_post_divide, .divisor_commit);

// [test/display_pll_control_bench.sv]
`timescale 1ns/100ps
module display_pll_control_bench;
    logic clock = 0, rst = 1, reg_write = 0, vblank_pulse = 0, panel_protect = 0, divisor_set_sel = 0;
    logic [3:0]  reg_byte_en = 0;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic        vco_power_on, pll_power_down, dot_clock_run, fast_io_clock_on, divisor_commit;
    logic [1:0]  pll_output_mode, second_post_divide_sel, m;
    logic [2:0]  video_clock_multiplier, reference_select;
    logic [7:0]  set0_first_post_divide, set1_first_post_divide;
    logic [5:0]  major_feedback_div, minor_feedback_div, input_div;
    logic [9:0]  feedback_total;
    logic [6:0]  input_total, post_total, pt [4] = '{7'd40, 7'd20, 7'd56, 7'd28};
    logic        config_error;
    int          failures = 0, checks_done = 0, i;

    dpllc_control dut (.clock(clock), .rst(rst), .reg_write(reg_write), .reg_byte_en(reg_byte_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .vblank_pulse(vblank_pulse),
        .panel_protect(panel_protect), .divisor_set_sel(divisor_set_sel),
        .pend_major_div(6'hC), .pend_minor_div(6'h9), .pend_input_div(6'h3),
        .vco_power_on(vco_power_on), .pll_power_down(pll_power_down), .dot_clock_run(dot_clock_run),
        .fast_io_clock_on(fast_io_clock_on), .pll_output_mode(pll_output_mode),
        .second_post_divide_sel(second_post_divide_sel), .video_clock_multiplier(video_clock_multiplier),
        .reference_select(reference_select), .set0_first_post_divide(set0_first_post_divide),
        .set1_first_post_divide(set1_first_post_divide), .divisor_commit(divisor_commit),
        .major_feedback_div(major_feedback_div), .minor_feedback_div(minor_feedback_div),
        .input_div(input_div), .feedback_total(feedback_total), .input_total(input_total),
        .post_total(post_total), .config_error(config_error));

    initial begin
        forever #20 clock = ~clock;
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask

    task wr(input logic [3:0] be, input logic [31:0] d);
        @(negedge clock);
        reg_write = 1;
        reg_byte_en = be;
        reg_wdata = d;
        @(negedge clock);
        reg_write = 0;
    endtask

    task vb;
        @(negedge clock);
        vblank_pulse = 1;
        @(negedge clock);
        vblank_pulse = 0;
    endtask

    task conclude;
        if (failures == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        conclude;
    end

    initial begin
        repeat (10) @(negedge clock);
        rst = 0;
        chk(reg_rdata, 32'h04800080);
        chk({vco_power_on, pll_power_down, video_clock_multiplier}, 5'h08);
        chk({set0_first_post_divide, set1_first_post_divide}, 16'h8080);
        wr(4'hF, 32'hF9087102);
        chk(reg_rdata, 32'hC9086002);
        chk({divisor_commit, major_feedback_div, minor_feedback_div, input_div}, {1'b1, 18'h0C243});
        chk({vco_power_on, pll_output_mode}, 3'h1);
        chk({set0_first_post_divide, set1_first_post_divide, reference_select}, {16'h0802, 3'h3});
        @(negedge clock);
        chk({feedback_total, input_total}, {10'd81, 7'd5});
        vb;
        chk({vco_power_on, pll_power_down, fast_io_clock_on, pll_output_mode, second_post_divide_sel,
            video_clock_multiplier}, {3'b101, 4'h9, 3'h0});
        @(negedge clock);
        chk(post_total, 7'd28);
        wr(4'h2, 32'h2400);
        chk(reg_rdata, 32'hC9082402);
        wr(4'h2, 32'h2E00);
        chk({reg_rdata, reference_select}, {32'hC9082402, 3'h1});
        wr(4'h1, 32'h08);
        chk({divisor_commit, set1_first_post_divide}, 9'h008);
        divisor_set_sel = 1;
        repeat (2) @(negedge clock);
        chk(post_total, 7'd28);
        for (i = 0; i < 4; i++) begin
            m = i[1] ? 2'h2 : 2'h1;
            wr(4'h8, {4'hC, m, 1'b0, i[0], 24'h0});
            vb;
            @(negedge clock);
            chk(post_total, pt[i]);
        end
        panel_protect = 1;
        wr(4'hF, 32'h0);
        chk(reg_rdata, 32'hC9082408);
        panel_protect = 0;
        wr(4'h8, 32'h09000000);
        vb;
        chk({vco_power_on, pll_power_down, dot_clock_run}, 3'h2);
        wr(4'h4, 32'h00100000);
        chk({divisor_commit, set0_first_post_divide}, 9'h110);
        conclude;
    end
endmodule // display_pll_control_bench
